// file: design/rs485_dir_map.svh
// Register map constants for the serial direction option block
// ----------------------------------------------------------------------------
// Overview of operation
// - Options register 0x12 for ports one, two
// - Options register 0x13 for ports three, four
// - Bit 0 enables port one auto direction
// - Bit 1 picks RTS (1) or DTR (0)
// - Bit 2 sets active drive level
// - Bits 4-6 same controls for port two
// - Second register bits 0-2 for port three
// - Second register bits 4-6 for port four
// ----------------------------------------------------------------------------
`ifndef RS485_DIR_MAP_SVH
`define RS485_DIR_MAP_SVH
`define OPT_PAIR_A_ADDR 8'h12
`define OPT_PAIR_B_ADDR 8'h13
`define OPT_RESET       8'h44
`define OPT_RSVD_MASK   8'h77
`define FLD_ENABLE      0
`define FLD_SELECT_RTS  1
`define FLD_POLARITY    2
`define FLD_PORT_STRIDE 4
`define AXI_RESP_OKAY   2'b00
`define AXI_RESP_SLVERR 2'b10
`endif

// file: design/rs485_dir_pkg.sv
// Types shared by the direction option block
package rs485_dir_pkg;
  typedef logic [7:0] opt_byte_t;
  typedef enum logic {
    IDLE_T,
    RESP_T
  } chan_state_t;
endpackage

// file: design/dir_port_if.sv
// Interface carrying one port's option bits and modem levels
`timescale 1ns/10ps
interface dir_port_if;
  logic       enable;
  logic       sel_rts;
  logic       polarity;
  logic       tx_busy;
  logic       rts_level;
  logic       dtr_level;
  logic       rts_pin;
  logic       dtr_pin;
  modport ctrl (input enable, sel_rts, polarity, tx_busy, rts_level, dtr_level, output rts_pin, dtr_pin);
  modport regs (output enable, sel_rts, polarity, tx_busy, rts_level, dtr_level, input rts_pin, dtr_pin);
endinterface

// file: design/dir_ctrl.sv
// Per-port direction driver onto the RTS or DTR output
`timescale 1ns/10ps
module dir_ctrl (
  input  wire logic MCLK_IN,
  input  wire logic RESET_N_IN,
  dir_port_if.ctrl  port
);
  // Active level while sending, opposite level otherwise
  wire drive_level = port.tx_busy ? port.polarity : ~port.polarity;
  wire rts_nxt     = (port.enable && port.sel_rts) ? drive_level : port.rts_level;
  wire dtr_nxt     = (port.enable && !port.sel_rts) ? drive_level : port.dtr_level;
  logic rts_r;
  logic dtr_r;
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rts_r <= 1'b1;
      dtr_r <= 1'b1;
    end else begin
      rts_r <= rts_nxt;
      dtr_r <= dtr_nxt;
    end
  end
  assign port.rts_pin = rts_r;
  assign port.dtr_pin = dtr_r;

  AST_DIR_ACTIVE: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    port.enable && port.tx_busy && port.sel_rts |=> (rts_r == $past(port.polarity)))
    else $error("rts not at active level while sending");
  AST_DIR_PASS: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !port.enable |=> (dtr_r == $past(port.dtr_level)) && (rts_r == $past(port.rts_level)))
    else $error("modem level not passed while disabled");
  AST_DIR_IDLE: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    port.enable && !port.tx_busy && !port.sel_rts |=> (dtr_r != $past(port.polarity)))
    else $error("dtr not inactive after transmit");
endmodule

// file: design/rs485_direction_options.sv
// AXI4-Lite option registers and direction control for four serial ports
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "rs485_dir_map.svh"
module rs485_direction_options #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                        MCLK_IN,
  input  wire logic                        RESET_N_IN,
  input  wire logic [7:0]                  S_AXI_AWADDR_IN,
  input  wire logic                        S_AXI_AWVALID_IN,
  output logic                             S_AXI_AWREADY_OUT,
  input  wire logic [31:0]                 S_AXI_WDATA_IN,
  input  wire logic [3:0]                  S_AXI_WSTRB_IN,
  input  wire logic                        S_AXI_WVALID_IN,
  output logic                             S_AXI_WREADY_OUT,
  output logic [1:0]                       S_AXI_BRESP_OUT,
  output logic                             S_AXI_BVALID_OUT,
  input  wire logic                        S_AXI_BREADY_IN,
  input  wire logic [7:0]                  S_AXI_ARADDR_IN,
  input  wire logic                        S_AXI_ARVALID_IN,
  output logic                             S_AXI_ARREADY_OUT,
  output logic [31:0]                      S_AXI_RDATA_OUT,
  output logic [1:0]                       S_AXI_RRESP_OUT,
  output logic                             S_AXI_RVALID_OUT,
  input  wire logic                        S_AXI_RREADY_IN,
  input  wire logic [NUM_PORTS-1:0]        TX_BUSY_IN,
  input  wire logic [NUM_PORTS-1:0]        MODEM_RTS_IN,
  input  wire logic [NUM_PORTS-1:0]        MODEM_DTR_IN,
  output logic [NUM_PORTS-1:0]             RTS_PIN_OUT,
  output logic [NUM_PORTS-1:0]             DTR_PIN_OUT
);
  import rs485_dir_pkg::*;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Register offsets are word indices; the byte address is four times the index
  function automatic logic [1:0] decode(input logic [7:0] addr);
    if (addr[1:0] != 2'b00) begin
      decode = 2'd0;
    end else if (addr[7:2] == `OPT_PAIR_A_ADDR) begin
      decode = 2'd1;
    end else if (addr[7:2] == `OPT_PAIR_B_ADDR) begin
      decode = 2'd2;
    end else begin
      decode = 2'd0;
    end
  endfunction

  opt_byte_t   opt_a_r;
  opt_byte_t   opt_b_r;
  chan_state_t wr_state_r;
  chan_state_t rd_state_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [7:0]  wdata_r;
  logic        wstrb0_r;
  logic [1:0]  bresp_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  wire        aw_take    = S_AXI_AWVALID_IN && !aw_held_r && (wr_state_r == IDLE_T);
  wire        w_take     = S_AXI_WVALID_IN && !w_held_r && (wr_state_r == IDLE_T);
  wire        aw_have    = aw_held_r || aw_take;
  wire        w_have     = w_held_r || w_take;
  wire        wr_go      = aw_have && w_have;
  wire [7:0]  wr_addr    = aw_held_r ? awaddr_r : S_AXI_AWADDR_IN;
  wire [7:0]  wr_data    = w_held_r ? wdata_r : S_AXI_WDATA_IN[7:0];
  wire        wr_lane0   = w_held_r ? wstrb0_r : S_AXI_WSTRB_IN[0];
  wire [1:0]  wr_sel     = decode(wr_addr);
  wire [1:0]  rd_sel     = decode(S_AXI_ARADDR_IN);
  wire        rd_take    = S_AXI_ARVALID_IN && (rd_state_r == IDLE_T);
  // Reserved bits 3 and 7 never store, so they read as zero
  wire [7:0]  wr_masked  = wr_data & `OPT_RSVD_MASK;
  wire [7:0]  rd_byte    = (rd_sel == 2'd1) ? opt_a_r : (rd_sel == 2'd2) ? opt_b_r : 8'h00;
  wire [1:0]  wr_resp    = (wr_sel == 2'd0) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
  wire [1:0]  rd_resp    = (rd_sel == 2'd0) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;

  assign S_AXI_AWREADY_OUT = !aw_held_r && (wr_state_r == IDLE_T);
  assign S_AXI_WREADY_OUT  = !w_held_r && (wr_state_r == IDLE_T);
  assign S_AXI_BVALID_OUT  = (wr_state_r == RESP_T);
  assign S_AXI_BRESP_OUT   = bresp_r;
  assign S_AXI_ARREADY_OUT = (rd_state_r == IDLE_T);
  assign S_AXI_RVALID_OUT  = (rd_state_r == RESP_T);
  assign S_AXI_RDATA_OUT   = rdata_r;
  assign S_AXI_RRESP_OUT   = rresp_r;

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      awaddr_r   <= 8'h00;
      wdata_r    <= 8'h00;
      wstrb0_r   <= 1'b0;
      bresp_r    <= `AXI_RESP_OKAY;
      wr_state_r <= IDLE_T;
    end else begin
      case (wr_state_r)
        IDLE_T: begin
          if (wr_go) begin
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            bresp_r    <= wr_resp;
            wr_state_r <= RESP_T;
          end else begin
            if (aw_take) begin
              aw_held_r <= 1'b1;
              awaddr_r  <= S_AXI_AWADDR_IN;
            end
            if (w_take) begin
              w_held_r <= 1'b1;
              wdata_r  <= S_AXI_WDATA_IN[7:0];
              wstrb0_r <= S_AXI_WSTRB_IN[0];
            end
          end
        end
        RESP_T: begin
          if (S_AXI_BREADY_IN) begin
            wr_state_r <= IDLE_T;
          end
        end
        default: wr_state_r <= IDLE_T;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Option registers
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      opt_a_r <= `OPT_RESET;
      opt_b_r <= `OPT_RESET;
    end else if (wr_go && (wr_state_r == IDLE_T) && wr_lane0) begin
      if (wr_sel == 2'd1) begin
        opt_a_r <= wr_masked;
      end else if (wr_sel == 2'd2) begin
        opt_b_r <= wr_masked;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= `AXI_RESP_OKAY;
      rd_state_r <= IDLE_T;
    end else begin
      case (rd_state_r)
        IDLE_T: begin
          if (rd_take) begin
            rdata_r    <= {24'h00_0000, rd_byte};
            rresp_r    <= rd_resp;
            rd_state_r <= RESP_T;
          end
        end
        RESP_T: begin
          if (S_AXI_RREADY_IN) begin
            rd_state_r <= IDLE_T;
          end
        end
        default: rd_state_r <= IDLE_T;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Per-port direction control
  // --------------------------------------------------------------------------
  wire [15:0] opt_all = {opt_b_r, opt_a_r};
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      dir_port_if pif ();
      // Port g uses the nibble at 4*g: one/two in the first byte, three/four in the second
      assign pif.enable    = opt_all[g*`FLD_PORT_STRIDE + `FLD_ENABLE];
      assign pif.sel_rts   = opt_all[g*`FLD_PORT_STRIDE + `FLD_SELECT_RTS];
      assign pif.polarity  = opt_all[g*`FLD_PORT_STRIDE + `FLD_POLARITY];
      assign pif.tx_busy   = TX_BUSY_IN[g];
      assign pif.rts_level = MODEM_RTS_IN[g];
      assign pif.dtr_level = MODEM_DTR_IN[g];
      assign RTS_PIN_OUT[g] = pif.rts_pin;
      assign DTR_PIN_OUT[g] = pif.dtr_pin;
      dir_ctrl u_dir (
        .MCLK_IN    (MCLK_IN),
        .RESET_N_IN (RESET_N_IN),
        .port       (pif.ctrl)
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_RESERVED_ZERO: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    ((opt_a_r | opt_b_r) & ~`OPT_RSVD_MASK) == 8'h00)
    else $error("reserved option bits set");
  AST_WRITE_A: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wr_go && (wr_state_r == IDLE_T) && wr_lane0 && (wr_sel == 2'd1)
    |=> opt_a_r == ($past(wr_data) & `OPT_RSVD_MASK))
    else $error("first options register not written");
  AST_WRITE_B: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    wr_go && (wr_state_r == IDLE_T) && wr_lane0 && (wr_sel == 2'd2)
    |=> opt_b_r == ($past(wr_data) & `OPT_RSVD_MASK))
    else $error("second options register not written");
  AST_READ_DATA: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    rd_take && (rd_sel == 2'd2) |=> S_AXI_RVALID_OUT && (S_AXI_RDATA_OUT[7:0] == $past(opt_b_r)))
    else $error("read data wrong");
  // The pin is registered, so it shows the polarity of the cycle before
  AST_PORT_ONE_EN: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    opt_a_r[0] && opt_a_r[1] && TX_BUSY_IN[0] ##1 opt_a_r[0] && opt_a_r[1]
    |-> RTS_PIN_OUT[0] == $past(opt_a_r[2]))
    else $error("port one rts not driven");
  AST_PORT_TWO_SEL: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    opt_a_r[4] && !opt_a_r[5] && TX_BUSY_IN[1] && $stable(opt_a_r)
    |=> DTR_PIN_OUT[1] == $past(opt_a_r[6]))
    else $error("port two dtr not driven");
  AST_PORT_FOUR: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    opt_b_r[4] && opt_b_r[5] && !TX_BUSY_IN[3] |=> RTS_PIN_OUT[3] == !$past(opt_b_r[6]))
    else $error("port four rts not inactive");
  AST_PORT_THREE: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    opt_b_r[0] && opt_b_r[1] && TX_BUSY_IN[2] |=> RTS_PIN_OUT[2] == $past(opt_b_r[2]))
    else $error("port three rts not active");
  AST_BRESP_HOLD: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write response dropped");
  COV_WRITE_A: cover property (@(posedge MCLK_IN) wr_go && (wr_sel == 2'd1));
  COV_READ_B: cover property (@(posedge MCLK_IN) rd_take && (rd_sel == 2'd2));
  COV_BAD_ADDR: cover property (@(posedge MCLK_IN) wr_go && (wr_sel == 2'd0));
  COV_TX_DRIVE: cover property (@(posedge MCLK_IN) opt_a_r[0] && TX_BUSY_IN[0]);
endmodule

// file: verification/rs485_xcvr_model.sv
// Behavioural model of the transceiver driver-enable input on each serial port
`timescale 1ns/10ps
module rs485_xcvr_model (
  input  wire logic [3:0] rts_in,
  input  wire logic [3:0] dtr_in,
  input  wire logic [3:0] use_rts_in,
  input  wire logic [3:0] active_high_in,
  output logic      [3:0] drive_en_out
);
  // ------------------------------------------------------------------
  // Driver enable
  // ------------------------------------------------------------------
  // Takes both modem lines; use_rts_in picks which one drives the enable
  assign drive_en_out = ~(((use_rts_in & rts_in) | (~use_rts_in & dtr_in)) ^ active_high_in);
endmodule

// file: verification/tb.sv
// Self-checking bench for the serial direction option block
`timescale 1ns/10ps
`include "rs485_dir_map.svh"
module tb;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, tx_busy, m_rts, m_dtr, rts, dtr, x_rts, x_act, de;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          n_fail, total_checks;

  rs485_direction_options uut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .TX_BUSY_IN(tx_busy), .MODEM_RTS_IN(m_rts), .MODEM_DTR_IN(m_dtr),
    .RTS_PIN_OUT(rts), .DTR_PIN_OUT(dtr));
  rs485_xcvr_model xcvr (.rts_in(rts), .dtr_in(dtr), .use_rts_in(x_rts), .active_high_in(x_act),
    .drive_en_out(de));

  // ------------------------------------------------------------------
  // Common tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    $display("mismatch at %0t: bus wait ran out", $time);
    test_done();
  endtask

  // Handshakes are judged at the negative edge, where ready is settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    chk(rts, 4'h3);
    chk(dtr, 4'hc);
    axi_rd(8'h48, d, r);
    chk(d, 32'h44);
    axi_rd(8'h4c, d, r);
    chk(d, 32'h44);
    chk(r, `AXI_RESP_OKAY);
  endtask

  task automatic reg_access();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h48, 32'hffffffff, 4'hf, r);
    axi_rd(8'h48, d, r);
    chk(d, 32'h77);
    axi_wr(8'h4c, 32'h5a, 4'hf, r);
    axi_rd(8'h4c, d, r);
    chk(d, 32'h52);
    // A write without its low strobe must leave the byte alone
    axi_wr(8'h48, 32'h0, 4'h0, r);
    chk(r, `AXI_RESP_OKAY);
    axi_rd(8'h48, d, r);
    chk(d, 32'h77);
    axi_wr(8'h50, 32'h11, 4'hf, r);
    chk(r, `AXI_RESP_SLVERR);
    axi_rd(8'h50, d, r);
    chk(d, 32'h0);
    chk(r, `AXI_RESP_SLVERR);
    axi_rd(8'h49, d, r);
    chk(r, `AXI_RESP_SLVERR);
  endtask

  // A reset in mid-run must bring written registers back to their reset byte
  task automatic mid_reset();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h48, 32'h33, 4'hf, r);
    axi_rd(8'h48, d, r);
    chk(d, 32'h33);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(rts, m_rts);
    chk(dtr, m_dtr);
    axi_rd(8'h48, d, r);
    chk(d, 32'h44);
    axi_rd(8'h4c, d, r);
    chk(d, 32'h44);
  endtask

  task automatic dir_case(input int g, input logic en, input logic sel, input logic pol);
    logic [3:0]  nib;
    logic [1:0]  r;
    logic        act;
    nib = {1'b0, pol, sel, en};
    axi_wr((g < 2) ? 8'h48 : 8'h4c, (g % 2) ? {24'h0, nib, 4'h0} : {28'h0, nib}, 4'hf, r);
    x_rts[g] <= sel;
    x_act[g] <= pol;
    for (int b = 0; b < 2; b++) begin
      m_rts <= {4{b[0]}} ^ 4'h5;
      m_dtr <= {4{b[0]}} ^ 4'ha;
      tx_busy <= 4'(b) << g;
      @(posedge clk);
      @(negedge clk);
      act = b[0] ? pol : ~pol;
      if (en) begin
        chk(sel ? rts[g] : dtr[g], act);
        chk(sel ? dtr[g] : rts[g], sel ? m_dtr[g] : m_rts[g]);
        chk(de[g], b[0]);
      end else begin
        chk({rts[g], dtr[g]}, {m_rts[g], m_dtr[g]});
      end
      @(posedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0; tx_busy = 4'h0;
    m_rts = 4'h3; m_dtr = 4'hc; x_rts = 4'h0; x_act = 4'h0;
    n_fail = 0; total_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_values();
    reg_access();
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 4; c++) dir_case(g, 1'b1, c[0], c[1]);
      dir_case(g, 1'b0, 1'b1, 1'b1);
    end
    mid_reset();
    test_done();
  end
endmodule
